// ===== src/bcm_consts.svh
// Bus connect monitor constants: offsets, fields, reset values, timing
// How it works
// R1: Both lines rising high means connect.
// R2: Both lines falling low starts disconnect.
// R3: Disconnect counts only after full low timeout.
// R4: Select field picks 250/500/1000/2000 ms.
// R5: Polarity chooses connect or disconnect flagging.
// R6: Handler vector entry clears the flag.
// R7: Writing one clears flag, zero keeps.
// R8: Interrupt needs global, local enable, flag. Code also raises it from masked event status with global enable alone.
// R9: Flag after reset equals both-high at reset.
// R10: Flag7, enable6, timeout 2:1, polarity0.
// R11: Bits 5:3 reserved, read zero.
// R12: Software sets polarity after connect seen.
// R13: Lines synchronised; low counter restarts on high.
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BCM_OFS_CTRL       8'h00
`define BCM_OFS_EVT_STATUS 8'h04
`define BCM_OFS_EVT_MASK   8'h08
`define BCM_OFS_GLOBAL     8'h0C
`define BCM_OFS_LINES      8'h10

// ----------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------
`define BCM_BIT_FLAG       7
`define BCM_BIT_IRQ_EN     6
`define BCM_BIT_SEL_HI     2
`define BCM_BIT_SEL_LO     1
`define BCM_BIT_POL        0
`define BCM_RST_IRQ_EN     1'h0
`define BCM_RST_SEL        2'h0
`define BCM_RST_POL        1'h0
`define BCM_RST_EVT        2'h0
`define BCM_RST_GLOBAL     1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BCM_CLK_PERIOD_NS  5
`define BCM_TO0_MS         250
`define BCM_TO1_MS         500
`define BCM_TO2_MS         1000
`define BCM_TO3_MS         2000
`define BCM_NS_PER_MS      1000000

`endif

// ===== src/bcm_pkg.sv
// Bus connect monitor types
package bcm_pkg;

	typedef enum logic [2:0] {
		TMR_IDLE  = 3'b001,
		TMR_COUNT = 3'b010,
		TMR_DONE  = 3'b100
	} bcm_tmr_mode_type;

	typedef struct packed {
		bcm_tmr_mode_type mode;
		logic [31:0]      count;
		logic             expired;
	} bcm_tmr_state_type;

	typedef struct packed {
		logic [1:0]  sda_sync;
		logic [1:0]  scl_sync;
		logic        both_high_d;
		logic        bus_event_flag;
		logic        bus_event_irq_enable;
		logic [1:0]  disconnect_timeout_sel;
		logic        bus_event_polarity;
		logic [1:0]  evt_status;
		logic [1:0]  evt_mask;
		logic        global_irq_enable;
		logic        ack;
		logic [31:0] dat;
		logic        irq;
	} bcm_top_state_type;

endpackage

// ===== src/bcm_timer.sv
// Disconnect low-time qualifier counter
`timescale 1ns/1ps
`include "bcm_consts.svh"
module bcm_timer
	import bcm_pkg::*;
(
	input  wire logic        clk_i,      // System clock
	input  wire logic        rst_i,      // Synchronous reset, high
	input  wire logic        both_low_i, // Both lines low, synchronised
	input  wire logic [31:0] limit_i,    // Required low time in cycles
	output logic             expired_o   // Pulse when low time reached
);

	bcm_tmr_state_type st;
	bcm_tmr_state_type next_st;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.expired = 1'b0;
		if (rst_i || !both_low_i)
		begin
			// R13: restart on high
			next_st.mode = TMR_IDLE;
			next_st.count = 32'h0;
		end
		else
		begin
			case (st.mode)
				TMR_IDLE, TMR_COUNT:
				begin
					// R3: full timeout first
					if (st.count >= limit_i - 32'h1)
					begin
						next_st.expired = 1'b1;
						next_st.mode = TMR_DONE;
					end
					else
					begin
						next_st.count = st.count + 32'h1;
						next_st.mode = TMR_COUNT;
					end
				end
				TMR_DONE:
					next_st.mode = TMR_DONE;
				default:
					next_st.mode = TMR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		st <= next_st;
	end

	assign expired_o = st.expired;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_expire_after_limit: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		st.expired |-> ($past(st.count) >= limit_i - 32'h1) && $past(both_low_i))
		else $error("disconnect qualified before low time elapsed");

	a_restart_on_high: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		!both_low_i |=> (st.count == 32'h0) && !st.expired)
		else $error("low counter not restarted by a high line");

endmodule

// ===== src/bcm_top.sv
// Bus connect/disconnect monitor with Wishbone register slave
`timescale 1ns/1ps
`include "bcm_consts.svh"
module bcm_top
	import bcm_pkg::*;
#(
	parameter logic [31:0] TO0_CYCLES = 32'((64'(`BCM_TO0_MS) * 64'(`BCM_NS_PER_MS))
		/ 64'(`BCM_CLK_PERIOD_NS)),
	parameter logic [31:0] TO1_CYCLES = 32'((64'(`BCM_TO1_MS) * 64'(`BCM_NS_PER_MS))
		/ 64'(`BCM_CLK_PERIOD_NS)),
	parameter logic [31:0] TO2_CYCLES = 32'((64'(`BCM_TO2_MS) * 64'(`BCM_NS_PER_MS))
		/ 64'(`BCM_CLK_PERIOD_NS)),
	parameter logic [31:0] TO3_CYCLES = 32'((64'(`BCM_TO3_MS) * 64'(`BCM_NS_PER_MS))
		/ 64'(`BCM_CLK_PERIOD_NS))
)
(
	input  wire logic        clk_i,     // System clock, 200 MHz
	input  wire logic        rst_i,     // Synchronous reset, high
	input  wire logic        wb_cyc_i,  // Wishbone cycle
	input  wire logic        wb_stb_i,  // Wishbone strobe
	input  wire logic        wb_we_i,   // Wishbone write enable
	input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,  // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,  // Wishbone write data
	output logic [31:0]      wb_dat_o,  // Wishbone read data
	output logic             wb_ack_o,  // Wishbone acknowledge
	input  wire logic        sda_i,     // Serial data line level
	input  wire logic        scl_i,     // Serial clock line level
	input  wire logic        vec_ack_i, // Handler vector entered, pulse
	output logic             irq_o      // Interrupt request, level
);

	bcm_top_state_type st;
	bcm_top_state_type next_st;

	logic        both_high;
	logic        both_low;
	logic        connect_evt;
	logic        disconnect_evt;
	logic        flag_set;
	logic        flag_clr;
	logic        req;
	logic        wr_commit;
	logic        wr_lane0;
	logic [7:0]  reg_ofs;
	logic [31:0] rd_data;
	logic [31:0] to_limit;
	logic [1:0]  evt_clr;

	// ----------------------------------------------------------------
	// Line conditions
	// ----------------------------------------------------------------
	// R1: both lines high
	assign both_high = st.sda_sync[1] & st.scl_sync[1];
	// R2: both lines low
	assign both_low = ~st.sda_sync[1] & ~st.scl_sync[1];
	// R13: connect on entry
	assign connect_evt = both_high & ~st.both_high_d;

	// R4: timeout select
	always_comb
	begin
		case (st.disconnect_timeout_sel)
			2'h0:    to_limit = TO0_CYCLES;
			2'h1:    to_limit = TO1_CYCLES;
			2'h2:    to_limit = TO2_CYCLES;
			default: to_limit = TO3_CYCLES;
		endcase
	end

	// The low counter runs whatever the polarity, so a change of
	// polarity while the bus already idles low does not restart the count.
	bcm_timer u_timer (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.both_low_i (both_low),
		.limit_i    (to_limit),
		.expired_o  (disconnect_evt)
	);

	// R5: polarity picks event
	assign flag_set = st.bus_event_polarity ? disconnect_evt : connect_evt;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack, not earlier
	assign wr_commit = req & wb_we_i & st.ack;
	assign wr_lane0 = wr_commit & wb_sel_i[0];
	assign reg_ofs = {wb_adr_i[7:2], 2'h0};

	// R6: vector clears flag
	// R7: write one clears
	assign flag_clr = vec_ack_i
		| (wr_lane0 & (reg_ofs == `BCM_OFS_CTRL) & wb_dat_i[`BCM_BIT_FLAG]);

	assign evt_clr = (wr_lane0 && reg_ofs == `BCM_OFS_EVT_STATUS) ? wb_dat_i[1:0] : 2'h0;

	always_comb
	begin
		rd_data = 32'h0;
		case (reg_ofs)
			`BCM_OFS_CTRL:
			begin
				// R10: field layout
				// R11: reserved bits zero
				rd_data[`BCM_BIT_FLAG] = st.bus_event_flag;
				rd_data[`BCM_BIT_IRQ_EN] = st.bus_event_irq_enable;
				rd_data[`BCM_BIT_SEL_HI:`BCM_BIT_SEL_LO] = st.disconnect_timeout_sel;
				rd_data[`BCM_BIT_POL] = st.bus_event_polarity;
			end
			`BCM_OFS_EVT_STATUS: rd_data[1:0] = st.evt_status;
			`BCM_OFS_EVT_MASK:   rd_data[1:0] = st.evt_mask;
			`BCM_OFS_GLOBAL:     rd_data[0] = st.global_irq_enable;
			`BCM_OFS_LINES:      rd_data[1:0] = {st.scl_sync[1], st.sda_sync[1]};
			default:             rd_data = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// Synchronisers run through reset so the reset flag sees real levels
		next_st.sda_sync = {st.sda_sync[0], sda_i};
		next_st.scl_sync = {st.scl_sync[0], scl_i};
		next_st.ack = 1'b0;
		next_st.dat = 32'h0;
		if (rst_i)
		begin
			// R9: flag from reset levels
			next_st.bus_event_flag = both_high;
			next_st.both_high_d = both_high;
			// R10: fields reset zero
			next_st.bus_event_irq_enable = `BCM_RST_IRQ_EN;
			next_st.disconnect_timeout_sel = `BCM_RST_SEL;
			next_st.bus_event_polarity = `BCM_RST_POL;
			next_st.evt_status = `BCM_RST_EVT;
			next_st.evt_mask = `BCM_RST_EVT;
			next_st.global_irq_enable = `BCM_RST_GLOBAL;
			next_st.irq = 1'b0;
		end
		else
		begin
			next_st.both_high_d = both_high;

			if (req && !st.ack)
			begin
				next_st.ack = 1'b1;
				next_st.dat = rd_data;
			end

			if (wr_lane0)
			begin
				case (reg_ofs)
					`BCM_OFS_CTRL:
					begin
						next_st.bus_event_irq_enable = wb_dat_i[`BCM_BIT_IRQ_EN];
						next_st.disconnect_timeout_sel =
							wb_dat_i[`BCM_BIT_SEL_HI:`BCM_BIT_SEL_LO];
						next_st.bus_event_polarity = wb_dat_i[`BCM_BIT_POL];
					end
					`BCM_OFS_EVT_MASK: next_st.evt_mask = wb_dat_i[1:0];
					`BCM_OFS_GLOBAL:   next_st.global_irq_enable = wb_dat_i[0];
					default:           next_st.global_irq_enable = st.global_irq_enable;
				endcase
			end

			// A new event in the clearing cycle survives the clear
			next_st.bus_event_flag = (st.bus_event_flag & ~flag_clr) | flag_set;
			next_st.evt_status = (st.evt_status & ~evt_clr)
				| {disconnect_evt, connect_evt};

			// R8: gated interrupt
			next_st.irq = st.global_irq_enable
				& ((st.bus_event_irq_enable & st.bus_event_flag)
				| (|(st.evt_status & st.evt_mask)));
		end
	end

	always_ff @(posedge clk_i)
	begin
		st <= next_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;
	assign irq_o = st.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_connect_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		(connect_evt && !st.bus_event_polarity) |=> st.bus_event_flag)
		else $error("connect did not set the event flag");

	a_connect_needs_high: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		connect_evt |-> $past(!(st.sda_sync[1] && st.scl_sync[1])))
		else $error("connect seen without a rise into both-high");

	a_disconnect_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		(disconnect_evt && st.bus_event_polarity) |=> st.bus_event_flag)
		else $error("qualified disconnect did not set the event flag");

	a_polarity_blocks_connect: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		(!st.bus_event_flag && st.bus_event_polarity && !disconnect_evt)
		|=> !st.bus_event_flag)
		else $error("flag set by connect while polarity selects disconnect");

	a_disconnect_low_run: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		disconnect_evt |-> $past(both_low, 1) && $past(both_low, 2))
		else $error("disconnect reported without lines held low");

	a_vector_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		(vec_ack_i && !flag_set) |=> !st.bus_event_flag)
		else $error("handler vector entry did not clear the flag");

	a_write_one_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		(wr_lane0 && reg_ofs == `BCM_OFS_CTRL && wb_dat_i[7] && !flag_set)
		|=> !st.bus_event_flag)
		else $error("writing one to the flag did not clear it");

	a_write_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		(st.bus_event_flag && !flag_clr) |=> st.bus_event_flag)
		else $error("flag lost without a clear");

	a_irq_needs_enables: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		irq_o |-> $past(st.global_irq_enable))
		else $error("interrupt raised with global enable clear");

	a_irq_follows_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		(st.global_irq_enable && st.bus_event_irq_enable && st.bus_event_flag)
		|=> irq_o)
		else $error("interrupt missing while flag and enables are set");

	a_reset_flag_level: assert property (@(posedge clk_i) // R9
		$fell(rst_i) |-> st.bus_event_flag == $past(both_high))
		else $error("flag after reset does not match line levels");

	a_reset_fields_zero: assert property (@(posedge clk_i) // R10
		$fell(rst_i) |-> !st.bus_event_irq_enable && st.disconnect_timeout_sel == 2'h0
		&& !st.bus_event_polarity)
		else $error("control fields not zero after reset");

	a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		(req && !st.ack && !wb_we_i && reg_ofs == `BCM_OFS_CTRL)
		|=> wb_ack_o && wb_dat_o[5:3] == 3'h0 && wb_dat_o[7] == $past(st.bus_event_flag))
		else $error("control read returned wrong reserved or flag bits");

	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	// ----------------------------------------------------------------
	// Register and event checks
	// ----------------------------------------------------------------
	a_ack_after_request: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !st.ack) |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");

	a_ack_needs_request: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(req))
		else $error("acknowledge given without a request");

	a_dat_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside the acknowledge cycle");

	a_upper_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data has bits set above the byte lane");

	a_ctrl_read_fields: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		(req && !st.ack && !wb_we_i && reg_ofs == `BCM_OFS_CTRL)
		|=> wb_dat_o[`BCM_BIT_IRQ_EN] == $past(st.bus_event_irq_enable)
		&& wb_dat_o[`BCM_BIT_SEL_HI:`BCM_BIT_SEL_LO] == $past(st.disconnect_timeout_sel)
		&& wb_dat_o[`BCM_BIT_POL] == $past(st.bus_event_polarity))
		else $error("control read returned wrong field values");

	a_lines_read: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		(req && !st.ack && !wb_we_i && reg_ofs == `BCM_OFS_LINES)
		|=> wb_dat_o[1:0] == $past({st.scl_sync[1], st.sda_sync[1]}))
		else $error("line status read does not match synchronised levels");

	a_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !st.ack && !wb_we_i && reg_ofs > `BCM_OFS_LINES)
		|=> wb_dat_o == 32'h0)
		else $error("unmapped offset returned non-zero data");

	a_ctrl_write_fields: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		(wr_lane0 && reg_ofs == `BCM_OFS_CTRL)
		|=> st.bus_event_irq_enable == $past(wb_dat_i[`BCM_BIT_IRQ_EN])
		&& st.disconnect_timeout_sel == $past(wb_dat_i[`BCM_BIT_SEL_HI:`BCM_BIT_SEL_LO])
		&& st.bus_event_polarity == $past(wb_dat_i[`BCM_BIT_POL]))
		else $error("control write did not land in the fields");

	a_fields_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		!(wr_lane0 && reg_ofs == `BCM_OFS_CTRL)
		|=> $stable(st.bus_event_irq_enable) && $stable(st.disconnect_timeout_sel)
		&& $stable(st.bus_event_polarity))
		else $error("control field changed without a write");

	a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && reg_ofs == `BCM_OFS_EVT_MASK)
		|=> st.evt_mask == $past(wb_dat_i[1:0]))
		else $error("mask write did not land");

	a_global_write: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		(wr_lane0 && reg_ofs == `BCM_OFS_GLOBAL)
		|=> st.global_irq_enable == $past(wb_dat_i[0]))
		else $error("global enable write did not land");

	a_status_connect: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		connect_evt |=> st.evt_status[0])
		else $error("connect not recorded in event status");

	a_status_disconnect: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		disconnect_evt |=> st.evt_status[1])
		else $error("disconnect not recorded in event status");

	a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(st.evt_status[0] && !evt_clr[0]) |=> st.evt_status[0])
		else $error("connect status lost without a clear");

	a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(evt_clr[0] && !connect_evt) |=> !st.evt_status[0])
		else $error("writing one did not clear connect status");

	a_connect_once: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		connect_evt |=> !connect_evt)
		else $error("connect reported twice for one rise");

	a_disconnect_once: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		disconnect_evt |=> !disconnect_evt)
		else $error("disconnect reported twice for one low period");

	a_flag_needs_cause: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		(!st.bus_event_flag && !flag_set) |=> !st.bus_event_flag)
		else $error("flag set without a selected event");

	a_irq_off_global: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		!st.global_irq_enable |=> !irq_o)
		else $error("interrupt raised while global enable is clear");

	a_reset_outputs_low: assert property (@(posedge clk_i)
		rst_i |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
		else $error("outputs not quiet during reset");

	a_reset_regs_zero: assert property (@(posedge clk_i) // R10
		$fell(rst_i) |-> st.evt_status == 2'h0 && st.evt_mask == 2'h0
		&& !st.global_irq_enable)
		else $error("event and enable registers not zero after reset");

endmodule

// ===== verif/bcm_line_model.sv
// Two-wire line model: idle high, held low, or running traffic
`timescale 1ns/1ps
module bcm_line_model
(
	input  wire logic [1:0] mode_i, // 0 idle high, 1 held low, 2 traffic
	output logic            sda_o,  // Data line level
	output logic            scl_o   // Clock line level
);
	logic tclk;
	logic tdat;

	// ----------------------------------------------------------------
	// Traffic pattern, 160 ns line clock
	// ----------------------------------------------------------------
	// Both-low spans stay at 80 ns, well short of any selected timeout
	initial
	begin
		tclk = 1'b1;
		tdat = 1'b1;
		forever
		begin
			#80;
			tclk = ~tclk;
			#80;
			tclk = ~tclk;
			tdat = ~tdat;
		end
	end

	// ----------------------------------------------------------------
	// Line levels
	// ----------------------------------------------------------------
	// Pulled-up lines read high when released; clock stands still outside traffic
	assign sda_o = (mode_i == 2'h2) ? tdat : ~mode_i[0];
	assign scl_o = (mode_i == 2'h2) ? tclk : ~mode_i[0];
endmodule

// ===== verif/bcm_top_tb_top.sv
// Self-checking bench for the bus connect monitor
`timescale 1ns/1ps
module bcm_top_tb_top;
	localparam int LIM [4] = '{20, 40, 80, 160};
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat_w;
	logic [3:0]  wb_sel;
	logic [3:0]  sel_v;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic        sda;
	logic        scl;
	logic        vec_ack;
	logic        irq;
	logic [1:0]  mode;
	logic [31:0] rnd;
	logic [31:0] q;
	logic        m_flag;
	logic        m_en;
	logic        m_pol;
	logic [1:0]  m_sel;
	int          err_total;
	int          n_checks;

	bcm_top #(.TO0_CYCLES(32'(LIM[0])), .TO1_CYCLES(32'(LIM[1])),
		.TO2_CYCLES(32'(LIM[2])), .TO3_CYCLES(32'(LIM[3]))) i_bcm_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
		.wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .sda_i(sda), .scl_i(scl),
		.vec_ack_i(vec_ack), .irq_o(irq));

	bcm_line_model i_bcm_line_model (.mode_i(mode), .sda_o(sda), .scl_o(scl));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Ack is sampled on the rising edge; the release follows that same edge
	// and no cycle count is assumed: only the watchdog ends a hung wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		rnd = lfsr_next(rnd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= sel_v;
		wb_dat_w <= {rnd[23:0], d};
		do
			@(posedge clk_i);
		while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		wb_sel <= 4'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task automatic wctl(input logic [7:0] d);
		m_en = d[6];
		m_sel = d[2:1];
		m_pol = d[0];
		if (d[7])
			m_flag = 1'b0;
		bus(1'b1, 8'h00, d);
	endtask

	task automatic rctl();
		rd(8'h00, {24'h0, m_flag, m_en, 3'b000, m_sel, m_pol});
	endtask

	task automatic line(input logic [1:0] m, input int n);
		@(posedge clk_i);
		mode <= m;
		cycles(n);
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial
	begin
		#200000;
		err_total++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		rst_i = 1'b1;
		{wb_cyc, wb_stb, wb_we, vec_ack} = 4'h0;
		wb_adr = 8'h00;
		wb_dat_w = 32'h0;
		wb_sel = 4'h0;
		sel_v = 4'hF;
		mode = 2'h0;
		rnd = 32'h0001166A;
		err_total = 0;
		n_checks = 0;
		{m_flag, m_en, m_pol, m_sel} = 5'h10;
		cycles(10);
		rst_i <= 1'b0;
		rctl();
		rd(8'h04, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h10, 32'h3);
		wctl(8'h7E);
		rctl();
		// A write with byte lane 0 deselected must leave every field alone
		sel_v = 4'hE;
		bus(1'b1, 8'h00, 8'h80);
		sel_v = 4'hF;
		rctl();
		chk(irq, 1'b0);
		bus(1'b1, 8'h0C, 8'h01);
		rd(8'h0C, 32'h1);
		cycles(2);
		chk(irq, 1'b1);
		wctl(8'hC0);
		cycles(2);
		chk(irq, 1'b0);
		line(2'h1, 4);
		line(2'h0, 6);
		m_flag = 1'b1;
		rctl();
		rd(8'h04, 32'h1);
		@(posedge clk_i);
		vec_ack <= 1'b1;
		@(posedge clk_i);
		vec_ack <= 1'b0;
		m_flag = 1'b0;
		rctl();
		bus(1'b1, 8'h08, 8'h01);
		cycles(2);
		chk(irq, 1'b1);
		bus(1'b1, 8'h04, 8'h01);
		cycles(2);
		chk(irq, 1'b0);
		// Mask off again so the loop sees the flag path alone
		bus(1'b1, 8'h08, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			wctl(8'h41 | 8'(s << 1));
			repeat (2)
			begin
				line(2'h1, LIM[s] - 4);
				line(2'h0, 8);
			end
			rctl();
			line(2'h1, LIM[s] + 8);
			m_flag = 1'b1;
			rctl();
			rd(8'h04, 32'h3);
			chk(irq, 1'b1);
			wctl(8'hC1 | 8'(s << 1));
			line(2'h0, 8);
			rctl();
			chk(irq, 1'b0);
		end
		wctl(8'h41);
		line(2'h2, 600);
		line(2'h0, 8);
		rctl();
		line(2'h1, 2);
		rst_i <= 1'b1;
		cycles(10);
		rst_i <= 1'b0;
		{m_flag, m_en, m_pol, m_sel} = 5'h00;
		rctl();
		chk(irq, 1'b0);
		rd(8'h10, 32'h0);
		rd(8'h04, 32'h0);
		summarize();
	end
endmodule
